// ==== hdl/porsq_top.sv ====
// Power-on reset sequencer: supply enables, fault checks and system reset release
// Functional notes
// - Power-on sequence starts only after first power-up of the backup supply.
// - Power-on reset puts all units in the hardware-reset state.
// - Battery fault must be high for sequencing to start; the sequencer stays off until it is.
// - System reset output asserted from start of power-on reset.
// - High-voltage supply enable asserted about 10 ms after reset release.
// - Low-voltage supply enable asserted about 125 ms after high enable.
// - Supply fault sampled only after both delay timers expire.
// - System reset released about 125 ms after low enable.
// - On leaving reset, run mode starts at the reset vector.
`timescale 1ns/1ps
module porsq_top #(
    parameter int unsigned CYC_PER_MS = porsq_pkg::CYC_PER_MS
) (
    // Clock and backup-supply power-up reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Pins from the power-control subsystem
    input  wire logic                   hw_rst_in_n,
    input  wire logic                   main_battery_fault_n,
    input  wire logic                   supply_fault_n,
    // Outputs to regulators and system
    output porsq_pkg::porsq_supply_t    supply_en,
    output logic                        system_rst_out_n,
    output logic                        run_mode
);
    porsq_pkg::porsq_state_t               state_q;
    logic [2:0]                            sync_q [2];
    logic                                  hw_rst_s;
    logic                                  batt_ok_s;
    logic                                  vdd_ok_s;
    logic [porsq_pkg::MS_CNT_W-1:0]        ms_cnt_q;
    logic                                  ms_tick;
    logic [porsq_pkg::DLY_CNT_W-1:0]       dly_q;
    logic                                  hv_timer_done_q;
    logic                                  lv_timer_done_q;
    logic                                  rst_seen_q;

    // Two-flop synchronisers; reset pin starts as released so only a real low arms the sequence
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_q[0] <= 3'h1;
            sync_q[1] <= 3'h1;
        end
        else
        begin
            sync_q[0] <= {supply_fault_n, main_battery_fault_n, hw_rst_in_n};
            sync_q[1] <= sync_q[0];
        end
    end
    assign hw_rst_s  = ~sync_q[1][0];
    assign batt_ok_s = sync_q[1][1];
    assign vdd_ok_s  = sync_q[1][2];

    // Millisecond enable divider; runs free, phase error under 1 ms
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ms_cnt_q <= '0;
        else if (ms_tick)
            ms_cnt_q <= '0;
        else
            ms_cnt_q <= ms_cnt_q + 1'b1;
    end
    assign ms_tick = (ms_cnt_q == porsq_pkg::MS_CNT_W'(CYC_PER_MS - 1));

    // Hardware reset must be seen once after power-up before the sequence can start
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_seen_q <= 1'b0;
        else if (hw_rst_s)
            rst_seen_q <= 1'b1;
    end

    // Sequencer; rst_n is the backup-supply power detect, everything returns to reset state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q         <= porsq_pkg::ST_OFF;
            dly_q           <= '0;
            hv_timer_done_q <= 1'b0;
            lv_timer_done_q <= 1'b0;
        end
        else if (hw_rst_s)
        begin
            // Hardware reset restarts the sequence; same state as power-on
            state_q         <= porsq_pkg::ST_OFF;
            dly_q           <= '0;
            hv_timer_done_q <= 1'b0;
            lv_timer_done_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                porsq_pkg::ST_OFF:
                begin
                    // Battery must be good to start, otherwise stay off until it turns good
                    if (rst_seen_q && batt_ok_s)
                    begin
                        state_q <= porsq_pkg::ST_WAIT_HV;
                        dly_q   <= '0;
                    end
                end
                porsq_pkg::ST_WAIT_HV:
                begin
                    if (ms_tick)
                    begin
                        if (dly_q == porsq_pkg::DLY_CNT_W'(porsq_pkg::HV_DELAY_MS - 1))
                        begin
                            state_q <= porsq_pkg::ST_WAIT_LV;
                            dly_q   <= '0;
                        end
                        else
                            dly_q <= dly_q + 1'b1;
                    end
                end
                porsq_pkg::ST_WAIT_LV:
                begin
                    if (ms_tick)
                    begin
                        if (dly_q == porsq_pkg::DLY_CNT_W'(porsq_pkg::LV_DELAY_MS - 1))
                        begin
                            state_q         <= porsq_pkg::ST_WAIT_RL;
                            hv_timer_done_q <= 1'b1;
                            dly_q           <= '0;
                        end
                        else
                            dly_q <= dly_q + 1'b1;
                    end
                end
                porsq_pkg::ST_WAIT_RL:
                begin
                    if (ms_tick)
                    begin
                        if (dly_q == porsq_pkg::DLY_CNT_W'(porsq_pkg::REL_DELAY_MS - 1))
                        begin
                            lv_timer_done_q <= 1'b1;
                            state_q         <= porsq_pkg::ST_HOLD;
                        end
                        else
                            dly_q <= dly_q + 1'b1;
                    end
                end
                porsq_pkg::ST_HOLD:
                begin
                    // Fault sampled only once both timers have run out
                    if (hv_timer_done_q && lv_timer_done_q && vdd_ok_s)
                        state_q <= porsq_pkg::ST_RUN;
                end
                porsq_pkg::ST_RUN:
                    state_q <= porsq_pkg::ST_RUN;
                default:
                    state_q <= porsq_pkg::ST_OFF;
            endcase
        end
    end

    // Outputs decoded from state; run mode releases the system reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            supply_en.high_volt_supply_en <= porsq_pkg::EN_RST;
            supply_en.low_volt_supply_en  <= porsq_pkg::EN_RST;
            system_rst_out_n              <= 1'b0;
            run_mode                      <= 1'b0;
        end
        else
        begin
            supply_en.high_volt_supply_en <= !hw_rst_s && (state_q inside {porsq_pkg::ST_WAIT_LV,
                porsq_pkg::ST_WAIT_RL, porsq_pkg::ST_HOLD, porsq_pkg::ST_RUN});
            supply_en.low_volt_supply_en  <= !hw_rst_s && (state_q inside {porsq_pkg::ST_WAIT_RL,
                porsq_pkg::ST_HOLD, porsq_pkg::ST_RUN});
            system_rst_out_n              <= !hw_rst_s && (state_q == porsq_pkg::ST_RUN);
            run_mode                      <= !hw_rst_s && (state_q == porsq_pkg::ST_RUN);
        end
    end

    // Checks
    property p_no_start_without_batt;
        @(posedge clk) disable iff (!rst_n)
        (state_q == porsq_pkg::ST_OFF && !batt_ok_s) |=> state_q == porsq_pkg::ST_OFF;
    endproperty
    a_no_start_without_batt: assert property (p_no_start_without_batt)
        else $error("sequence started with battery fault");

    property p_lv_after_hv;
        @(posedge clk) disable iff (!rst_n)
        $rose(supply_en.low_volt_supply_en) |-> supply_en.high_volt_supply_en;
    endproperty
    a_lv_after_hv: assert property (p_lv_after_hv)
        else $error("low supply enabled before high supply");

    property p_rst_out_needs_lv;
        @(posedge clk) disable iff (!rst_n)
        system_rst_out_n |-> supply_en.low_volt_supply_en;
    endproperty
    a_rst_out_needs_lv: assert property (p_rst_out_needs_lv)
        else $error("system reset released without low supply");

    property p_hold_on_fault;
        @(posedge clk) disable iff (!rst_n)
        (state_q == porsq_pkg::ST_HOLD && !vdd_ok_s && !hw_rst_s) |=>
            (state_q == porsq_pkg::ST_HOLD && !system_rst_out_n);
    endproperty
    a_hold_on_fault: assert property (p_hold_on_fault)
        else $error("system reset released with supply fault");

    property p_ignore_fault_early;
        @(posedge clk) disable iff (!rst_n)
        // Release decision is two edges before the output rises
        $rose(system_rst_out_n) |-> $past(hv_timer_done_q && lv_timer_done_q && vdd_ok_s, 2);
    endproperty
    a_ignore_fault_early: assert property (p_ignore_fault_early)
        else $error("reset released before timers expired with supply good");

    property p_run_matches_rst;
        @(posedge clk) disable iff (!rst_n)
        run_mode == system_rst_out_n;
    endproperty
    a_run_matches_rst: assert property (p_run_matches_rst)
        else $error("run mode and reset output disagree");

    property p_hwrst_asserts_out;
        @(posedge clk) disable iff (!rst_n)
        hw_rst_s |=> !system_rst_out_n && !supply_en.high_volt_supply_en;
    endproperty
    a_hwrst_asserts_out: assert property (p_hwrst_asserts_out)
        else $error("reset output not asserted under hardware reset");

    property p_hv_rise_from_wait;
        @(posedge clk) disable iff (!rst_n)
        $rose(supply_en.high_volt_supply_en) |-> $past(state_q, 2) == porsq_pkg::ST_WAIT_HV;
    endproperty
    a_hv_rise_from_wait: assert property (p_hv_rise_from_wait)
        else $error("high supply enable rose outside its delay");

endmodule : porsq_top

// ==== shared/porsq_pkg.sv ====
// Package for the power-on reset sequencer: timing constants, states and pin bundles
package porsq_pkg;

    // Clock rate in Hz
    localparam int unsigned CLK_HZ        = 20_000_000;
    // Sequencer delays in milliseconds
    localparam int unsigned HV_DELAY_MS   = 10;
    localparam int unsigned LV_DELAY_MS   = 125;
    localparam int unsigned REL_DELAY_MS  = 125;
    // Cycles per millisecond
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    // Millisecond tick counter width
    localparam int unsigned MS_CNT_W      = 15;
    // Millisecond delay counter width
    localparam int unsigned DLY_CNT_W     = 8;
    // Reset value of the supply enables
    localparam logic        EN_RST        = 1'b0;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_OFF     = 6'h01,
        ST_WAIT_HV = 6'h02,
        ST_WAIT_LV = 6'h04,
        ST_WAIT_RL = 6'h08,
        ST_HOLD    = 6'h10,
        ST_RUN     = 6'h20
    } porsq_state_t;

    // Supply enables toward the regulators
    typedef struct packed {
        logic high_volt_supply_en;
        logic low_volt_supply_en;
    } porsq_supply_t;

endpackage : porsq_pkg

// ==== sim/porsq_pwr_model.sv ====
// Behavioural power-control subsystem facing the sequencer
`timescale 1ns/1ps
module porsq_pwr_model #(
    parameter int unsigned CYC_PER_MS = 4
) (
    // Clock, power and bench commands
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     req_rst,
    input  wire logic                     batt_ok,
    input  wire logic                     stuck,
    input  wire logic [15:0]              pg_dly,
    // Pins of the sequencer
    input  wire porsq_pkg::porsq_supply_t supply_en,
    output logic                          hw_rst_in_n,
    output logic                          main_battery_fault_n,
    output logic                          supply_fault_n
);
    int hold;
    int pg;
    logic fault_n_d;
    initial
    begin
        hw_rst_in_n = 1'h0;
        supply_fault_n = 1'h0;
        hold = 0;
        pg = 0;
    end
    assign main_battery_fault_n = batt_ok;
    // Commands taken at the edge so bench writes never race; pins move just after it
    always @(posedge clk)
    begin
        if (!rst_n || req_rst)
            hold = 0;
        else if (hold < 10 * CYC_PER_MS)
            hold++;
        pg = supply_en.low_volt_supply_en ? pg + 1 : 0;
        fault_n_d = (pg >= pg_dly) && !stuck;
        #2;
        hw_rst_in_n = (hold >= 10 * CYC_PER_MS);
        supply_fault_n = fault_n_d;
    end
endmodule : porsq_pwr_model

// ==== sim/test_porsq_top.sv ====
// Self-checking bench for the power-on reset sequencer
`timescale 1ns/1ps
module test_porsq_top;
    localparam int unsigned CPM = 4;
    typedef struct packed {logic [3:0] v; int lo; int hi;} porsq_note_t;
    logic clk = 1'h0;
    logic rst_n = 1'h1;
    logic req_rst = 1'h0;
    logic batt_ok = 1'h1;
    logic stuck = 1'h0;
    logic [15:0] pg_dly = 16'h0010;
    logic [31:0] seed = 32'hA2BB;
    porsq_pkg::porsq_supply_t supply_en;
    logic hw_rst_in_n, main_battery_fault_n, supply_fault_n, system_rst_out_n, run_mode;
    logic [3:0] v_now;
    logic [3:0] v_prev = 4'h0;
    logic hw_prev = 1'h0;
    logic bf_prev = 1'h1;
    porsq_note_t notes[$];
    porsq_note_t n;
    int t = 0;
    int err_total = 0;
    int check_count = 0;

    porsq_top #(.CYC_PER_MS(CPM)) i_porsq_top (.clk(clk), .rst_n(rst_n), .hw_rst_in_n(hw_rst_in_n),
        .main_battery_fault_n(main_battery_fault_n), .supply_fault_n(supply_fault_n),
        .supply_en(supply_en), .system_rst_out_n(system_rst_out_n), .run_mode(run_mode));
    porsq_pwr_model #(.CYC_PER_MS(CPM)) i_porsq_pwr_model (.clk(clk), .rst_n(rst_n), .req_rst(req_rst),
        .batt_ok(batt_ok), .stuck(stuck), .pg_dly(pg_dly), .supply_en(supply_en), .hw_rst_in_n(hw_rst_in_n),
        .main_battery_fault_n(main_battery_fault_n), .supply_fault_n(supply_fault_n));

    always #25 clk = ~clk;
    // Output vector: high enable, low enable, reset release, run
    assign v_now = {supply_en.high_volt_supply_en, supply_en.low_volt_supply_en, system_rst_out_n, run_mode};

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xorshift

    task automatic final_report;
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    task automatic expect_ev(input logic [3:0] v, input int lo, input int hi);
        notes.push_back('{v, lo, hi});
    endtask : expect_ev

    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #2;
    endtask : idle

    // Bounded wait until every queued output change has been seen
    task automatic wait_empty(input int lim);
        for (int k = 0; k < lim && notes.size() != 0; k++)
        begin
            @(posedge clk);
            #2;
        end
        if (notes.size() != 0)
        begin
            err_total++;
            $display("MISMATCH pending_changes expected 0 seen %0d", notes.size());
            final_report();
        end
    endtask : wait_empty

    // Windows allow the free ms divider phase and the input synchronizer
    task automatic start_seq(input bit rel);
        seed = xorshift(seed);
        pg_dly = 16'(seed % 480 + 1);
        expect_ev(4'h8, 36, 50);
        expect_ev(4'hC, 494, 506);
        if (rel)
            expect_ev(4'hF, 494, 510);
    endtask : start_seq

    task automatic abort_seq;
        req_rst = 1'h1;
        expect_ev(4'h0, 0, 6);
        wait_empty(20);
    endtask : abort_seq

    // Each output change takes the oldest note; t counts from the last cause
    always @(posedge clk)
    begin
        if (hw_rst_in_n !== hw_prev || main_battery_fault_n !== bf_prev)
            t = 0;
        else
            t++;
        hw_prev = hw_rst_in_n;
        bf_prev = main_battery_fault_n;
        if (v_now !== v_prev)
        begin
            check_count++;
            n = notes.size() != 0 ? notes.pop_front() : porsq_note_t'{v_prev, -1, -1};
            if (n.v !== v_now || t < n.lo || t > n.hi)
            begin
                err_total++;
                $display("MISMATCH outputs expected %h in %0d..%0d seen %h at %0d", n.v, n.lo, n.hi, v_now, t);
            end
            t = 0;
            v_prev = v_now;
        end
    end

    initial
    begin
        // Reset falls after time zero so every reset process sees the edge
        #1;
        rst_n = 1'h0;
        idle(16);
        rst_n = 1'h1;
        start_seq(1);
        wait_empty(2000);
        // Battery bad at release: nothing may move until it turns good
        abort_seq();
        batt_ok = 1'h0;
        req_rst = 1'h0;
        idle(300);
        start_seq(1);
        batt_ok = 1'h1;
        wait_empty(1500);
        // Abort just after the high enable, then a stuck supply fault
        abort_seq();
        req_rst = 1'h0;
        expect_ev(4'h8, 36, 50);
        wait_empty(200);
        abort_seq();
        stuck = 1'h1;
        start_seq(0);
        req_rst = 1'h0;
        wait_empty(1500);
        idle(700);
        // Release follows the fault clearing by pin delay, sync and two register stages
        expect_ev(4'hF, 704, 708);
        stuck = 1'h0;
        wait_empty(10);
        // Second power-on reset in mid-run
        rst_n = 1'h0;
        expect_ev(4'h0, 0, 3);
        wait_empty(10);
        idle(15);
        rst_n = 1'h1;
        start_seq(1);
        wait_empty(2000);
        final_report();
    end
endmodule : test_porsq_top
